//--- design/amr_router.sv
`timescale 1ns/1ps
// Overview of operation
// - bit-band region 0x20000000, alias 0x22000000
// - alias write sets/clears one bit atomically
// - alias read returns the single bit
// - external window 0x60000000, 24 address bits
// - external data bus 8 or 16 bits
// - external fetch only when 16-bit wide
// - each external beat takes four clock cycles
// - serves synchronous or asynchronous memories
// - one memory type active at once
// - pins built with logic blocks, ports
// - no code protection on external window
// - code buses carry code range only
// - system bus ranges for data, debug
// - system bus fetches 0x20000000-0x3FFFFFFF
// - system control only via private bus
// - unaligned word/halfword completes, no extra cycles
// - 32 KB SRAM each side of 0x20000000
// - external port control registers selected
module amr_router
    import amr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire amr_req_s req,
    input wire logic xmem_wide,
    input wire logic xmem_sync,
    input wire logic [15:0] xmem_rdata,
    input wire logic [31:0] ppb_rdata,
    input wire logic [31:0] xctl_rdata,
    output amr_rsp_s rsp,
    output amr_path_e path,
    output amr_xmem_s xmem,
    output logic ppb_sel,
    output logic xctl_sel,
    output logic busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD = 3'b001,
        ST_MOD = 3'b011,
        ST_XM = 3'b010,
        ST_DONE = 3'b110
    } amr_st_e;

    logic [7:0] mem [0:(2**(SRAM_AW+1))*4-1];
    amr_st_e st_ff;
    amr_req_s cur_ff;
    amr_path_e path_ff;
    amr_rsp_s rsp_ff;
    amr_xmem_s xm_ff;
    logic ppb_ff, xctl_ff, err_ff, wide_ff, sync_ff;
    logic [2:0] cnt_ff;
    logic [1:0] beat_ff;
    logic [31:0] acc_ff;
    amr_path_e nxt_path;
    logic nxt_err;
    logic [31:0] a;
    logic is_alias, is_sram;
    logic [31:0] bb_byte;
    logic [4:0] bb_bit;
    logic [SRAM_AW+2:0] sidx;
    logic [2:0] nbytes;
    logic [31:0] word_rd;
    logic alias_ff;

    // ------------------------------------------------
    // address decode
    // ------------------------------------------------
    always_comb begin
        a = req.addr;
        is_alias = (a >= ALIAS_BASE) && (a <= ALIAS_LAST);
        // alias to byte and bit
        bb_byte = BB_BASE + {12'h000, a[24:7], 2'h0};
        bb_bit = a[6:2];
        is_sram = ((a >= CSRAM_BASE) && (a <= SRAM_LAST))
            || (is_alias && bb_byte <= SRAM_LAST);
        nxt_path = AMR_NONE;
        nxt_err = 1'b0;
        if (a <= CODE_LAST) begin
            nxt_path = AMR_CODE;
            nxt_err = !is_sram;
        end else if (a >= PPB_BASE && a <= PPB_LAST) begin
            nxt_path = AMR_PPB;
        end else if (a >= XMEM_BASE && a <= XMEM_LAST) begin
            nxt_path = AMR_XMEM;
            nxt_err = req.fetch && !xmem_wide;
        end else if (a >= XCTL_BASE && a <= XCTL_LAST) begin
            nxt_path = AMR_XCTL;
            nxt_err = req.fetch;
        end else if (a <= SYS_LAST || a >= SYS2_BASE) begin
            nxt_path = AMR_SYS;
            nxt_err = !is_sram || (req.fetch && a > SRAM_REGION_LAST);
        end
        if (nxt_path == AMR_NONE) begin
            nxt_err = 1'b1;
        end
    end

    always_comb begin
        sidx = cur_ff.addr[SRAM_AW+2:0] ^ {1'b1, {(SRAM_AW+2){1'b0}}};
        nbytes = 3'h1 << cur_ff.size;
        word_rd = '0;
        for (int i = 0; i < 4; i++) begin
            word_rd[i*8 +: 8] = mem[sidx + (SRAM_AW+3)'(i)];
        end
    end

    // ------------------------------------------------
    // sequencer
    // ------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff <= ST_IDLE;
            cur_ff <= '0;
            path_ff <= AMR_NONE;
            err_ff <= 1'b0;
            cnt_ff <= '0;
            beat_ff <= '0;
            acc_ff <= '0;
            wide_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (req.valid) begin
                        cur_ff <= req;
                        path_ff <= nxt_path;
                        err_ff <= nxt_err;
                        wide_ff <= xmem_wide;
                        sync_ff <= xmem_sync;
                        cnt_ff <= '0;
                        beat_ff <= '0;
                        if (is_alias && !nxt_err) begin
                            cur_ff.addr <= bb_byte & 32'hFFFF_FFFC;
                            cur_ff.size <= 2'h2;
                            st_ff <= ST_RD;
                        end else if (nxt_path == AMR_XMEM && !nxt_err) begin
                            st_ff <= ST_XM;
                        end else begin
                            st_ff <= ST_DONE;
                        end
                        acc_ff <= {27'h0, bb_bit};
                    end
                end
                ST_RD: begin
                    st_ff <= ST_MOD; // read then modify, no gap
                end
                ST_MOD: begin
                    acc_ff <= {31'h0, word_rd[acc_ff[4:0]]};
                    st_ff <= ST_DONE;
                end
                ST_XM: begin
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'(XMEM_CYCLES - 1)) begin
                        cnt_ff <= '0;
                        if (wide_ff) begin
                            acc_ff[beat_ff[0]*16 +: 16] <= xmem_rdata;
                        end else begin
                            acc_ff[beat_ff*8 +: 8] <= xmem_rdata[7:0];
                        end
                        beat_ff <= beat_ff + 2'h1;
                        if ({1'b0, beat_ff} + 3'h1 >=
                            (wide_ff ? (nbytes + 3'h1) >> 1 : nbytes)) begin
                            st_ff <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    st_ff <= ST_IDLE;
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // sram storage
    // ------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (st_ff == ST_MOD && cur_ff.write) begin
            mem[sidx + (SRAM_AW+3)'(acc_ff[4:3])][acc_ff[2:0]] <=
                cur_ff.wdata[0];
        end else if (st_ff == ST_DONE && cur_ff.write && !err_ff && !alias_ff
                     && path_ff != AMR_PPB && path_ff != AMR_XCTL
                     && path_ff != AMR_XMEM) begin
            for (int i = 0; i < 4; i++) begin
                if (3'(i) < nbytes) begin
                    mem[sidx + (SRAM_AW+3)'(i)] <= cur_ff.wdata[i*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------
    // external memory pins
    // ------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            xm_ff <= '0;
        end else begin
            xm_ff.cs <= (st_ff == ST_XM);
            xm_ff.rd <= (st_ff == ST_XM) && !cur_ff.write;
            xm_ff.wr <= (st_ff == ST_XM) && cur_ff.write
                && cnt_ff == 3'h1;
            xm_ff.clk_en <= (st_ff == ST_XM) && sync_ff
                && cnt_ff[0];
            xm_ff.addr <= cur_ff.addr[XADDR_W-1:0]
                + XADDR_W'(wide_ff ? {beat_ff, 1'b0} : {1'b0, beat_ff});
            xm_ff.wdata <= wide_ff ? cur_ff.wdata[beat_ff*16 +: 16]
                : {8'h00, cur_ff.wdata[beat_ff*8 +: 8]};
        end
    end

    // ------------------------------------------------
    // response
    // ------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rsp_ff <= '0;
            ppb_ff <= 1'b0;
            xctl_ff <= 1'b0;
        end else begin
            ppb_ff <= (st_ff == ST_IDLE) && req.valid && nxt_path == AMR_PPB;
            xctl_ff <= (st_ff == ST_IDLE) && req.valid
                && nxt_path == AMR_XCTL && !nxt_err;
            rsp_ff.done <= (st_ff == ST_DONE);
            rsp_ff.error <= (st_ff == ST_DONE) && err_ff;
            rsp_ff.rdata <= '0;
            if (st_ff == ST_DONE && !err_ff && !cur_ff.write) begin
                case (path_ff)
                    AMR_PPB: rsp_ff.rdata <= ppb_rdata;
                    AMR_XCTL: rsp_ff.rdata <= xctl_rdata;
                    AMR_XMEM: rsp_ff.rdata <= acc_ff;
                    default: rsp_ff.rdata <= is_alias_cur() ? acc_ff
                        : word_rd;
                endcase
            end
        end
    end

    function automatic logic is_alias_cur();
        return cur_ff.size == 2'h2 && acc_ff[31:1] == '0
            && cur_ff.addr[31:20] == BB_BASE[31:20] && alias_ff;
    endfunction : is_alias_cur

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            alias_ff <= 1'b0;
        end else if (st_ff == ST_IDLE && req.valid) begin
            alias_ff <= is_alias && !nxt_err;
        end
    end

    logic busy_ff;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (st_ff != ST_IDLE) ? (st_ff != ST_DONE) : req.valid;
        end
    end

    assign rsp = rsp_ff;
    assign path = path_ff;
    assign xmem = xm_ff;
    assign ppb_sel = ppb_ff;
    assign xctl_sel = xctl_ff;
    assign busy = busy_ff;
endmodule : amr_router

//--- design/amr_pkg.sv
package amr_pkg;
    localparam logic [31:0] CODE_LAST = 32'h1FFF_FFFF;
    localparam logic [31:0] CSRAM_BASE = 32'h1FFF_8000;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_LAST = 32'h2000_7FFF;
    localparam logic [31:0] BB_BASE = 32'h2000_0000;
    localparam logic [31:0] BB_LAST = 32'h200F_FFFF;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ALIAS_LAST = 32'h23FF_FFFF;
    localparam logic [31:0] SRAM_REGION_LAST = 32'h3FFF_FFFF;
    localparam logic [31:0] XCTL_BASE = 32'h4000_5400;
    localparam logic [31:0] XCTL_LAST = 32'h4000_54FF;
    localparam logic [31:0] XMEM_BASE = 32'h6000_0000;
    localparam logic [31:0] XMEM_LAST = 32'h60FF_FFFF;
    localparam logic [31:0] SYS_LAST = 32'hDFFF_FFFF;
    localparam logic [31:0] PPB_BASE = 32'hE000_0000;
    localparam logic [31:0] PPB_LAST = 32'hE00F_FFFF;
    localparam logic [31:0] SYS2_BASE = 32'hE010_0000;
    localparam int XADDR_W = 24;
    localparam int SRAM_AW = 13;
    localparam int XMEM_CYCLES = 4;

    typedef enum logic [2:0] {
        AMR_NONE = 3'h0,
        AMR_CODE = 3'h1,
        AMR_SYS = 3'h2,
        AMR_PPB = 3'h3,
        AMR_XMEM = 3'h4,
        AMR_XCTL = 3'h5
    } amr_path_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } amr_req_s;

    typedef struct packed {
        logic done;
        logic error;
        logic [31:0] rdata;
    } amr_rsp_s;

    typedef struct packed {
        logic [XADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic cs;
        logic rd;
        logic wr;
        logic clk_en;
    } amr_xmem_s;
endpackage : amr_pkg

//--- sim/amr_xmem_dev.sv
`timescale 1ns/1ps
module amr_xmem_dev
    import amr_pkg::*;
(
    input wire logic sys_clk,
    input wire amr_xmem_s xmem,
    output logic [15:0] xmem_rdata
);
    logic [15:0] mem [logic [XADDR_W-1:0]];
    logic [15:0] last;
    initial begin
        last = 16'h0000;
        xmem_rdata = 16'hFFFF;
    end
    // ------------------------------
    // memory behaviour
    // ------------------------------
    always @(posedge sys_clk) begin
        if (xmem.cs && xmem.wr) begin
            mem[xmem.addr] = xmem.wdata;
        end
        if (xmem.cs && xmem.rd) begin
            last = mem.exists(xmem.addr) ? mem[xmem.addr] : xmem.addr[15:0];
            xmem_rdata <= last;
        end else begin
            xmem_rdata <= ~last;
        end
    end
endmodule : amr_xmem_dev

//--- sim/amr_router_assertions.sv
`timescale 1ns/1ps
module amr_router_chk
    import amr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire amr_req_s req,
    input wire logic xmem_wide,
    input wire amr_rsp_s rsp,
    input wire amr_path_e path,
    input wire amr_xmem_s xmem,
    input wire logic ppb_sel,
    input wire logic xctl_sel,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic tk;
    logic [31:0] a;
    assign tk = req.valid && !busy;
    assign a = req.addr;
    // ------------------------------
    // checks
    // ------------------------------
    a_take_busy: assert property (tk |=> busy)
        else $error("busy not raised");
    a_done_pulse: assert property (rsp.done |=> !rsp.done)
        else $error("done held");
    a_err_done: assert property (rsp.error |-> rsp.done)
        else $error("error without done");
    a_sram_lat: assert property (tk && a >= SRAM_BASE && a <= SRAM_LAST
        |-> ##2 rsp.done && !rsp.error)
        else $error("sram latency");
    a_alias_lat: assert property (tk && a >= ALIAS_BASE && a <= ALIAS_LAST
        |=> !rsp.done [*3] ##1 rsp.done)
        else $error("alias latency");
    a_unmap_err: assert property (tk && a < CSRAM_BASE
        |-> ##2 rsp.done && rsp.error)
        else $error("unmapped not refused");
    a_ppb_route: assert property (tk && a >= PPB_BASE && a <= PPB_LAST
        |=> ppb_sel && path == AMR_PPB)
        else $error("ppb not selected");
    a_xctl_route: assert property (tk && a >= XCTL_BASE && a <= XCTL_LAST
        |=> xctl_sel && path == AMR_XCTL)
        else $error("port control not selected");
    a_narrow_fetch: assert property (tk && req.fetch && !xmem_wide &&
        a >= XMEM_BASE && a <= XMEM_LAST |-> ##2 rsp.error)
        else $error("narrow fetch allowed");
    a_cs_path: assert property (xmem.cs |-> path == AMR_XMEM)
        else $error("chip select off path");
    a_wr_in_cs: assert property (xmem.wr |-> xmem.cs)
        else $error("write strobe without select");
    a_clken_in_cs: assert property (xmem.clk_en |-> xmem.cs)
        else $error("clock enable without select");
endmodule : amr_router_chk

//--- sim/tb_amr_router.sv
`timescale 1ns/1ps
module tb_amr_router;
    import amr_pkg::*;
    logic sys_clk, reset, xmem_wide, xmem_sync, ppb_sel, xctl_sel, busy, er;
    logic [15:0] xmem_rdata;
    logic [31:0] ppb_rdata, xctl_rdata, rd, w, a;
    amr_req_s req;
    amr_rsp_s rsp;
    amr_path_e path;
    amr_xmem_s xmem;
    int num_errors, comparisons, lat, o, b;
    logic [31:0] um [6] = '{32'h0, 32'h1000_0000, 32'h2000_8000,
        32'h4000_0000, 32'hA000_0000, 32'hE010_0000};
    amr_router i_amr_router(.sys_clk(sys_clk), .reset(reset), .req(req),
        .xmem_wide(xmem_wide), .xmem_sync(xmem_sync), .xmem_rdata(xmem_rdata),
        .ppb_rdata(ppb_rdata), .xctl_rdata(xctl_rdata), .rsp(rsp), .path(path),
        .xmem(xmem), .ppb_sel(ppb_sel), .xctl_sel(xctl_sel), .busy(busy));
    amr_xmem_dev i_amr_xmem_dev(.sys_clk(sys_clk), .xmem(xmem),
        .xmem_rdata(xmem_rdata));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic acc(logic wr, logic fe, logic [31:0] ad, logic [31:0] d);
        @(posedge sys_clk);
        #1;
        req = '{1'b1, wr, fe, 2'h2, ad, d};
        lat = 0;
        er = 1'b1;
        while (lat < 60) begin
            @(posedge sys_clk);
            #1;
            lat++;
            if (rsp.done === 1'b1) begin
                rd = rsp.rdata;
                er = rsp.error;
                break;
            end
        end
        req.valid = 1'b0;
        if (lat == 60) chk("done", 32'h0, 32'h1);
    endtask : acc
    task automatic summarize();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // ------------------------------
    // tests
    // ------------------------------
    initial begin
        reset = 1'b1;
        req = '0;
        xmem_wide = 1'b1;
        xmem_sync = 1'b0;
        ppb_rdata = 32'h0;
        xctl_rdata = 32'h0;
        num_errors = 0;
        comparisons = 0;
        void'($urandom(65));
        repeat (3) @(posedge sys_clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            a = (i % 2 ? CSRAM_BASE : SRAM_BASE) + 32'($urandom_range(8191)) * 4;
            w = $urandom;
            acc(1'b1, 1'b0, a, w);
            acc(1'b0, 1'b0, a, 32'h0);
            chk("sram", w, rd);
            chk("sram_lat", 32'h2, 32'(lat));
        end
        w = $urandom | 32'h8;
        acc(1'b1, 1'b0, SRAM_BASE, w);
        acc(1'b0, 1'b0, 32'h2200_000C, 32'h0);
        chk("alias_rd", 32'h1, rd);
        acc(1'b1, 1'b0, 32'h2200_000C, 32'hFFFF_FFFE);
        acc(1'b0, 1'b0, SRAM_BASE, 32'h0);
        chk("alias_clr", w & ~32'h8, rd);
        for (int i = 0; i < 8; i++) begin
            o = $urandom_range(32767);
            b = $urandom_range(7);
            acc(1'b0, 1'b0, SRAM_BASE + 32'(o & ~3), 32'h0);
            w = rd | (32'h1 << (8 * (o % 4) + b));
            acc(1'b1, 1'b0, ALIAS_BASE + 32'(32 * o + 4 * b), 32'h1);
            acc(1'b0, 1'b0, SRAM_BASE + 32'(o & ~3), 32'h0);
            chk("alias_set", w, rd);
        end
        foreach (um[k]) begin
            a = um[k];
            acc(k % 2 == 1, 1'b0, a, 32'h0);
            chk("unmapped", 32'h1, {31'h0, er});
        end
        ppb_rdata = $urandom;
        acc(1'b0, 1'b0, PPB_BASE + 32'h4, 32'h0);
        chk("ppb", ppb_rdata, rd);
        xctl_rdata = $urandom;
        acc(1'b0, 1'b0, XCTL_LAST - 32'h3, 32'h0);
        chk("xctl", xctl_rdata, rd);
        for (int m = 0; m < 4; m++) begin
            xmem_wide = m[0];
            xmem_sync = m[1];
            a = XMEM_BASE + 32'($urandom_range(24'h3F_FFFF)) * 4;
            w = $urandom;
            acc(1'b1, 1'b0, a, w);
            acc(1'b0, 1'b0, a, 32'h0);
            chk("xmem", w, rd);
            chk("xmem_lat", m[0] ? 32'd10 : 32'd18, 32'(lat));
            acc(1'b0, 1'b1, a, 32'h0);
            chk("xfetch", {31'h0, ~m[0]}, {31'h0, er});
            if (m[0]) chk("xfetch_data", w, rd);
        end
        summarize();
    end
    initial begin
        #300000;
        num_errors++;
        summarize();
    end
endmodule : tb_amr_router

bind amr_router amr_router_chk i_amr_router_chk(.sys_clk(sys_clk),
    .reset(reset), .req(req), .xmem_wide(xmem_wide), .rsp(rsp), .path(path),
    .xmem(xmem), .ppb_sel(ppb_sel), .xctl_sel(xctl_sel), .busy(busy));
